// [design/cps_pkg.sv]
package cps_pkg;

	// register offsets on the management port
	localparam logic [7:0] REG_OE_CTRL = 8'h02;
	localparam logic [7:0] REG_FN_CTRL = 8'h05;

	// reset values
	localparam logic [7:0] OE_CTRL_RESET = 8'hff;
	localparam logic [7:0] FN_CTRL_RESET = 8'h00;

	// output_enable_ctrl fields
	localparam int OE_BIT_OUT_ZERO = 0;
	localparam int OE_BIT_OUT_ONE  = 1;
	localparam int OE_BIT_OUT_TWO  = 2;

	// pin_function_ctrl fields; low nibble is read-only strap status
	localparam int         FN_BIT_REQ_A_EN  = 7;
	localparam int         FN_BIT_REQ_A_SEL = 6;
	localparam int         FN_BIT_REQ_B_EN  = 5;
	localparam int         FN_BIT_REQ_B_SEL = 4;
	localparam int         FN_BIT_DONE      = 3;
	localparam int         FN_BIT_LEVEL_HI  = 2;
	localparam int         FN_BIT_LEVEL_LO  = 1;
	localparam int         FN_BIT_TRUSTED   = 0;
	localparam logic [7:0] FN_WRITE_MASK    = 8'hf0;

	// reference pairs and which request input may govern them
	localparam int NUM_PAIRS     = 5;
	localparam int PAIR_A_SEL_0  = 0;
	localparam int PAIR_A_SEL_1  = 2;
	localparam int PAIR_B_SEL_0  = 1;
	localparam int PAIR_B_SEL_1  = 4;
	localparam int NUM_BUS_CLKS  = 3;
	localparam int SMB_BYTE_BITS = 8;

	// three-level test-select strap
	typedef enum logic [1:0] {
		LVL_LOW  = 2'b00,
		LVL_MID  = 2'b01,
		LVL_HIGH = 2'b11
	} cps_level_type;

	typedef enum logic [2:0] {
		ST_WAIT  = 3'b001,
		ST_RUN   = 3'b010,
		ST_PDOWN = 3'b100
	} cps_strap_type;

	typedef enum logic [8:0] {
		SM_IDLE  = 9'b000000001,
		SM_ADDR  = 9'b000000010,
		SM_AACK  = 9'b000000100,
		SM_CMD   = 9'b000001000,
		SM_CACK  = 9'b000010000,
		SM_WDATA = 9'b000100000,
		SM_WACK  = 9'b001000000,
		SM_RDATA = 9'b010000000,
		SM_RACK  = 9'b100000000
	} cps_smb_type;

endpackage

// [design/cps_sync2.sv]
`timescale 1ns/100ps
// two-flop synchroniser; only the second stage is visible outside
module cps_sync2 #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta <= RST_VAL;
			q_o  <= RST_VAL;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule

// [design/cps_link_pins.sv]
`timescale 1ns/100ps
// bus clock pin drivers, running on the bus clock source domain
module cps_link_pins
	import cps_pkg::*;
#(
	parameter int N = NUM_BUS_CLKS
) (
	input  wire logic         link_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [N-1:0] en_i,
	output logic      [N-1:0] pin_o,
	output logic      [N-1:0] pin_oe_o
);
	logic         link_rst_n;
	logic [N-1:0] en_s;
	logic [N-1:0] next_pin;

	cps_sync2 #(.W(1), .RST_VAL(1'b0)) u_rst (
		.clk_i   (link_clk_i),
		.rst_n_i (1'b1),
		.d_i     (rst_n_i),
		.q_o     (link_rst_n)
	);

	cps_sync2 #(.W(N), .RST_VAL('0)) u_en (
		.clk_i   (link_clk_i),
		.rst_n_i (link_rst_n),
		.d_i     (en_i),
		.q_o     (en_s)
	);

	// divide-by-two toggle; a disabled pin parks low and floats
	always_comb begin
		for (int i = 0; i < N; i++) begin
			next_pin[i] = en_s[i] ? ~pin_o[i] : 1'b0;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			pin_o    <= '0;
			pin_oe_o <= '0;
		end else begin
			pin_o    <= next_pin;
			pin_oe_o <= en_s; // RULE3
		end
	end
endmodule

// [design/cps_top.sv]
`timescale 1ns/100ps
// Notes on behaviour
// RULE1: after power-up shared pin zero is bus clock output zero, later reassignable as request A.
// RULE2: the host disables bus clock output zero in byte 2 bit 0 before enabling request A.
// RULE3: a disabled bus clock output on a shared pin is left floating so it can serve as input.
// RULE4: byte 5 bit 7 picks pin zero's function, 0 clock output by default, 1 request A.
// RULE5: byte 5 bit 6 picks the pair request A governs, 0 pair 0 by default, 1 pair 2.
// RULE6: the host disables bus clock output one in byte 2 bit 1 before enabling request B.
// RULE7: byte 5 bit 5 picks pin one's function, 0 clock output by default, 1 request B.
// RULE8: byte 5 bit 4 picks the pair request B governs, 0 pair 1 by default, 1 pair 4.
// RULE9: the trusted-mode strap is sampled at power-up, low allows and high forbids overclocking.
// RULE10: once the trusted strap is sampled, pin two becomes bus clock output two.
// RULE11: the reference pin is latched as a three-level test-select strap that sets test mode.
// RULE12: the reference pin is a low-threshold frequency-select input, otherwise the reference clock.
// RULE13: straps are sampled when power-good shows valid power, and its loss means power-down.
// RULE14: an enabled request input runs its chosen pair while low and stops it while high.
module cps_top
	import cps_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
	// clocks and reset
	input  wire logic                 CLK_I,
	input  wire logic                 RSTN_I,
	input  wire logic                 LINK_CLK_I,
	// management port
	input  wire logic                 SCLK_I,
	input  wire logic                 SDATA_I,
	output logic                      SDATA_O,
	output logic                      SDATA_OE_O,
	// shared pins
	input  wire logic                 CLOCK_REQUEST_A_IN_I,
	output logic                      BUS_CLOCK_OUT_ZERO_O,
	output logic                      BUS_CLOCK_OUT_ZERO_OE_O,
	input  wire logic                 CLOCK_REQUEST_B_IN_I,
	output logic                      BUS_CLOCK_OUT_ONE_O,
	output logic                      BUS_CLOCK_OUT_ONE_OE_O,
	input  wire logic                 TRUSTED_MODE_STRAP_I,
	output logic                      BUS_CLOCK_OUT_TWO_O,
	output logic                      BUS_CLOCK_OUT_TWO_OE_O,
	// reference pin
	input  wire logic                 CPU_FREQ_SELECT_C_I,
	input  wire logic                 TEST_SELECT_MID_I,
	input  wire logic                 XTAL_CLOCK_I,
	output logic                      REFERENCE_CLOCK_OUT_O,
	output logic                      REFERENCE_CLOCK_OUT_OE_O,
	// power and strap state
	input  wire logic                 POWER_GOOD_POWERDOWN_I,
	output logic                      CPU_FREQ_SELECT_C_O,
	output logic                      TRUSTED_MODE_O,
	output logic [1:0]                TEST_LEVEL_O,
	output logic                      TEST_MODE_O,
	output logic                      POWER_DOWN_O,
	output logic [NUM_PAIRS-1:0]      REFERENCE_PAIR_RUN_O
);
	// ---- input synchronisers ----
	logic [7:0] pins_s;
	logic       scl_s, sda_s, req_a_s, req_b_s, tme_s, fsc_s, mid_s, pg_s, xtal_s;

	cps_sync2 #(.W(8), .RST_VAL(8'h1f)) u_pins (
		.clk_i   (CLK_I),
		.rst_n_i (RSTN_I),
		.d_i     ({XTAL_CLOCK_I, POWER_GOOD_POWERDOWN_I, TEST_SELECT_MID_I,
		            CPU_FREQ_SELECT_C_I, TRUSTED_MODE_STRAP_I, CLOCK_REQUEST_B_IN_I,
		            CLOCK_REQUEST_A_IN_I, SCLK_I}),
		.q_o     (pins_s)
	);
	assign {xtal_s, pg_s, mid_s, fsc_s, tme_s, req_b_s, req_a_s, scl_s} = pins_s;

	cps_sync2 #(.W(1), .RST_VAL(1'b1)) u_sda (
		.clk_i   (CLK_I),
		.rst_n_i (RSTN_I),
		.d_i     (SDATA_I),
		.q_o     (sda_s)
	);

	// ---- management port slave ----
	cps_smb_type sm, next_sm;
	logic [3:0]  cnt, next_cnt;
	logic [7:0]  shift, next_shift, ptr, next_ptr;
	logic [7:0]  oe_ctrl, next_oe_ctrl, fn_ctrl, next_fn_ctrl;
	logic        rw, next_rw, nack, next_nack, sda_oe, next_sda_oe;
	logic        scl_d, sda_d;
	logic        scl_rise, scl_fall, bus_start, bus_stop;
	logic [7:0]  status;

	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] oe,
	                                        input logic [7:0] fn, input logic [7:0] st);
		case (a)
			REG_OE_CTRL: reg_read = oe;
			REG_FN_CTRL: reg_read = (fn & FN_WRITE_MASK) | (st & ~FN_WRITE_MASK);
			default:     reg_read = 8'h00;
		endcase
	endfunction

	always_comb begin
		next_sm      = sm;
		next_cnt     = cnt;
		next_shift   = shift;
		next_ptr     = ptr;
		next_rw      = rw;
		next_nack    = nack;
		next_sda_oe  = sda_oe;
		next_oe_ctrl = oe_ctrl;
		next_fn_ctrl = fn_ctrl;
		if (bus_start) begin
			next_sm     = SM_ADDR;
			next_cnt    = 4'h0;
			next_sda_oe = 1'b0;
		end else if (bus_stop) begin
			next_sm     = SM_IDLE;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (sm)
				SM_ADDR, SM_CMD, SM_WDATA: begin
					next_shift = {shift[6:0], sda_s};
					next_cnt   = cnt + 4'h1;
				end
				SM_RDATA: next_cnt = cnt + 4'h1;
				SM_RACK:  next_nack = sda_s;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (sm)
				SM_ADDR: if (cnt == 4'(SMB_BYTE_BITS)) begin
					next_rw = shift[0];
					if (shift[7:1] == DEV_ADDR) begin
						next_sm     = SM_AACK;
						next_sda_oe = 1'b1;
					end else begin
						next_sm = SM_IDLE;
					end
				end
				SM_AACK: begin
					next_cnt = 4'h0;
					if (rw) begin
						next_sm     = SM_RDATA;
						next_shift  = reg_read(ptr, oe_ctrl, fn_ctrl, status);
						next_sda_oe = ~next_shift[7];
					end else begin
						next_sm     = SM_CMD;
						next_sda_oe = 1'b0;
					end
				end
				SM_CMD: if (cnt == 4'(SMB_BYTE_BITS)) begin
					next_ptr    = shift;
					next_sm     = SM_CACK;
					next_sda_oe = 1'b1;
				end
				SM_CACK, SM_WACK: begin
					next_sm     = SM_WDATA;
					next_cnt    = 4'h0;
					next_sda_oe = 1'b0;
				end
				SM_WDATA: if (cnt == 4'(SMB_BYTE_BITS)) begin
					// pin functions change only on this write
					if (ptr == REG_OE_CTRL) next_oe_ctrl = shift;
					if (ptr == REG_FN_CTRL) next_fn_ctrl = shift & FN_WRITE_MASK; // RULE4
					next_ptr    = ptr + 8'h01;
					next_sm     = SM_WACK;
					next_sda_oe = 1'b1;
				end
				SM_RDATA: begin
					if (cnt == 4'(SMB_BYTE_BITS)) begin
						next_sm     = SM_RACK;
						next_sda_oe = 1'b0;
					end else begin
						next_sda_oe = ~shift[3'(7 - cnt)];
					end
				end
				SM_RACK: begin
					if (nack) begin
						next_sm = SM_IDLE;
					end else begin
						next_ptr    = ptr + 8'h01;
						next_sm     = SM_RDATA;
						next_cnt    = 4'h0;
						next_shift  = reg_read(next_ptr, oe_ctrl, fn_ctrl, status);
						next_sda_oe = ~next_shift[7];
					end
				end
				default: next_sm = SM_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			sm         <= SM_IDLE;
			cnt        <= 4'h0;
			shift      <= 8'h00;
			ptr        <= 8'h00;
			rw         <= 1'b0;
			nack       <= 1'b0;
			sda_oe     <= 1'b0;
			oe_ctrl    <= OE_CTRL_RESET;
			fn_ctrl    <= FN_CTRL_RESET; // RULE1
			scl_d      <= 1'b1;
			sda_d      <= 1'b1;
			SDATA_O    <= 1'b0;
			SDATA_OE_O <= 1'b0;
		end else begin
			sm         <= next_sm;
			cnt        <= next_cnt;
			shift      <= next_shift;
			ptr        <= next_ptr;
			rw         <= next_rw;
			nack       <= next_nack;
			sda_oe     <= next_sda_oe;
			oe_ctrl    <= next_oe_ctrl;
			fn_ctrl    <= next_fn_ctrl;
			scl_d      <= scl_s;
			sda_d      <= sda_s;
			SDATA_O    <= 1'b0;
			SDATA_OE_O <= next_sda_oe;
		end
	end

	// ---- straps and power state ----
	cps_strap_type st, next_st;
	logic          next_trusted, next_fsc, next_pdown, strap_done;
	logic [1:0]    next_level;

	assign strap_done = (st != ST_WAIT);
	assign status     = {4'h0, strap_done, TEST_LEVEL_O, TRUSTED_MODE_O};

	always_comb begin
		next_st      = st;
		next_trusted = TRUSTED_MODE_O;
		next_fsc     = CPU_FREQ_SELECT_C_O;
		next_level   = TEST_LEVEL_O;
		case (st)
			ST_WAIT: if (pg_s) begin
				next_trusted = tme_s; // RULE9 RULE13
				next_fsc     = fsc_s; // RULE12
				next_level   = fsc_s ? LVL_HIGH : (mid_s ? LVL_MID : LVL_LOW); // RULE11
				next_st      = ST_RUN;
			end
			ST_RUN:   if (!pg_s) next_st = ST_PDOWN; // RULE13
			ST_PDOWN: if (pg_s) next_st = ST_RUN;
			default:  next_st = ST_WAIT;
		endcase
		next_pdown = (next_st != ST_RUN);
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			st                  <= ST_WAIT;
			TRUSTED_MODE_O      <= 1'b0;
			CPU_FREQ_SELECT_C_O <= 1'b0;
			TEST_LEVEL_O        <= LVL_LOW;
			TEST_MODE_O         <= 1'b0;
			POWER_DOWN_O        <= 1'b1;
		end else begin
			st                  <= next_st;
			TRUSTED_MODE_O      <= next_trusted;
			CPU_FREQ_SELECT_C_O <= next_fsc;
			TEST_LEVEL_O        <= next_level;
			TEST_MODE_O         <= (next_level == LVL_HIGH); // RULE11
			POWER_DOWN_O        <= next_pdown;
		end
	end

	// ---- pin functions and pair gating ----
	logic                 run, fn_a, fn_b;
	logic [2:0]           bus_en, next_bus_en;
	logic [NUM_PAIRS-1:0] next_pair_run;
	logic                 next_ref_oe, next_ref_out;

	assign run  = (st == ST_RUN);
	assign fn_a = fn_ctrl[FN_BIT_REQ_A_EN];
	assign fn_b = fn_ctrl[FN_BIT_REQ_B_EN];

	always_comb begin
		// either disable path floats the pin, so a host slip cannot cause contention
		next_bus_en[0] = run & oe_ctrl[OE_BIT_OUT_ZERO] & ~fn_a; // RULE1 RULE2 RULE3 RULE4
		next_bus_en[1] = run & oe_ctrl[OE_BIT_OUT_ONE] & ~fn_b;  // RULE6 RULE7
		next_bus_en[2] = run & oe_ctrl[OE_BIT_OUT_TWO];          // RULE10
		for (int p = 0; p < NUM_PAIRS; p++) begin
			next_pair_run[p] = run;
			if (fn_a && req_a_s && p == (fn_ctrl[FN_BIT_REQ_A_SEL] ? PAIR_A_SEL_1
			                                                       : PAIR_A_SEL_0))
				next_pair_run[p] = 1'b0; // RULE5 RULE14
			if (fn_b && req_b_s && p == (fn_ctrl[FN_BIT_REQ_B_SEL] ? PAIR_B_SEL_1
			                                                       : PAIR_B_SEL_0))
				next_pair_run[p] = 1'b0; // RULE8 RULE14
		end
		// limitation: the oscillator is resampled, so the edge carries one cycle of jitter
		next_ref_oe  = run; // RULE12
		next_ref_out = run & xtal_s;
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			bus_en                   <= 3'h0;
			REFERENCE_PAIR_RUN_O     <= '0;
			REFERENCE_CLOCK_OUT_OE_O <= 1'b0;
			REFERENCE_CLOCK_OUT_O    <= 1'b0;
		end else begin
			bus_en                   <= next_bus_en;
			REFERENCE_PAIR_RUN_O     <= next_pair_run;
			REFERENCE_CLOCK_OUT_OE_O <= next_ref_oe;
			REFERENCE_CLOCK_OUT_O    <= next_ref_out;
		end
	end

	cps_link_pins #(.N(NUM_BUS_CLKS)) u_link (
		.link_clk_i (LINK_CLK_I),
		.rst_n_i    (RSTN_I),
		.en_i       (bus_en),
		.pin_o      ({BUS_CLOCK_OUT_TWO_O, BUS_CLOCK_OUT_ONE_O, BUS_CLOCK_OUT_ZERO_O}),
		.pin_oe_o   ({BUS_CLOCK_OUT_TWO_OE_O, BUS_CLOCK_OUT_ONE_OE_O,
		              BUS_CLOCK_OUT_ZERO_OE_O})
	);

	// ---- assertions ----
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);

	sequence s_pg_in_wait;
		(st == ST_WAIT) && pg_s;
	endsequence
	sequence s_latched;
		strap_done && !POWER_DOWN_O;
	endsequence

	property p_out0_default;
		(run && oe_ctrl[OE_BIT_OUT_ZERO] && !fn_a) |=> bus_en[0];
	endproperty
	a_out0_default: assert property (p_out0_default) else $error("clock out zero not enabled"); // RULE1
	property p_float_disabled;
		(!oe_ctrl[OE_BIT_OUT_ZERO] || fn_a) |=> !bus_en[0] && !bus_en[0] [*1];
	endproperty
	a_float_disabled: assert property (p_float_disabled) else $error("pin zero still driven"); // RULE3
	property p_req_a_pair;
		(fn_a && req_a_s && run) |=>
			!REFERENCE_PAIR_RUN_O[$past(fn_ctrl[FN_BIT_REQ_A_SEL]) ? PAIR_A_SEL_1 : PAIR_A_SEL_0];
	endproperty
	a_req_a_pair: assert property (p_req_a_pair) else $error("request A did not stop pair"); // RULE5
	property p_req_b_pair;
		(fn_b && req_b_s && run) |=>
			!REFERENCE_PAIR_RUN_O[$past(fn_ctrl[FN_BIT_REQ_B_SEL]) ? PAIR_B_SEL_1 : PAIR_B_SEL_0];
	endproperty
	a_req_b_pair: assert property (p_req_b_pair) else $error("request B did not stop pair"); // RULE8
	property p_pin_one_fn;
		fn_b |=> !bus_en[1];
	endproperty
	a_pin_one_fn: assert property (p_pin_one_fn) else $error("pin one driven as request"); // RULE7
	property p_trusted_latch;
		s_pg_in_wait |=> (TRUSTED_MODE_O == $past(tme_s)) ##1 $stable(TRUSTED_MODE_O);
	endproperty
	a_trusted_latch: assert property (p_trusted_latch) else $error("trusted strap mislatched"); // RULE9
	property p_pin_two_wait;
		(st == ST_WAIT) |=> !bus_en[2];
	endproperty
	a_pin_two_wait: assert property (p_pin_two_wait) else $error("pin two driven before strap"); // RULE10
	property p_test_mode;
		strap_done |-> (TEST_MODE_O == (TEST_LEVEL_O == LVL_HIGH));
	endproperty
	a_test_mode: assert property (p_test_mode) else $error("test mode mismatch"); // RULE11
	property p_ref_input_wait;
		(st == ST_WAIT) |=> !REFERENCE_CLOCK_OUT_OE_O;
	endproperty
	a_ref_input_wait: assert property (p_ref_input_wait) else $error("reference pin driven early"); // RULE12
	property p_pg_latch;
		s_pg_in_wait |=> s_latched;
	endproperty
	a_pg_latch: assert property (p_pg_latch) else $error("straps not latched on power good"); // RULE13
	property p_req_a_run;
		(fn_a && !req_a_s && !fn_b && run && pg_s) |=> REFERENCE_PAIR_RUN_O == {NUM_PAIRS{1'b1}};
	endproperty
	a_req_a_run: assert property (p_req_a_run) else $error("pair stopped with request low"); // RULE14
endmodule

// [bench/cps_smb_host.sv]
`timescale 1ns/100ps
// management host; the shared data line has a pull-up, so it is high unless someone pulls it
module cps_smb_host #(
	parameter logic [6:0] DEV_ADDR = 7'h2a
) (
	input  wire logic clk_i,
	input  wire logic sdata_oe_i,
	output logic      sclk_o,
	output logic      sdata_o
);
	logic host_sda;
	assign sdata_o = host_sda & ~sdata_oe_i;
	initial begin
		sclk_o = 1'b1;
		host_sda = 1'b1;
	end
	// phases of 6 clocks keep clear of the 2-clock minimum that the input synchroniser needs
	task automatic half();
		repeat (6) @(posedge clk_i);
	endtask
	// also serves as repeated start when the clock is low
	task automatic start();
		host_sda <= 1'b1;
		half();
		sclk_o <= 1'b1;
		half();
		host_sda <= 1'b0;
		half();
		sclk_o <= 1'b0;
		half();
	endtask
	task automatic stop();
		host_sda <= 1'b0;
		half();
		sclk_o <= 1'b1;
		half();
		host_sda <= 1'b1;
		half();
	endtask
	task automatic clk_bit(input logic b, output logic seen);
		host_sda <= b;
		half();
		sclk_o <= 1'b1;
		half();
		seen = sdata_o;
		sclk_o <= 1'b0;
		half();
	endtask
	// last = 1 releases the line in the ninth slot: device ack on writes, host nack on reads
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
			output logic ack);
		for (int i = 7; i >= 0; i--) begin
			clk_bit(tx[i], rx[i]);
		end
		clk_bit(last, ack);
	endtask
	task automatic smb_write(input logic [7:0] off, input logic [7:0] v, output logic ok);
		logic [7:0] rx;
		logic       a0, a1, a2;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
		xfer(off, 1'b1, rx, a1);
		xfer(v, 1'b1, rx, a2);
		stop();
		ok = ~(a0 | a1 | a2);
	endtask
	task automatic smb_read(input logic [7:0] off, output logic [7:0] v, output logic ok);
		logic [7:0] rx;
		logic       a0, a1, a2, nk;
		start();
		xfer({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
		xfer(off, 1'b1, rx, a1);
		start();
		xfer({DEV_ADDR, 1'b1}, 1'b1, rx, a2);
		xfer(8'hff, 1'b1, v, nk);
		stop();
		ok = ~(a0 | a1 | a2);
	endtask
endmodule

// [bench/cps_top_tb.sv]
`timescale 1ns/100ps
module cps_top_tb;
	import cps_pkg::*;
	localparam logic [6:0] DEV = 7'h2a;
	logic                 clk = 1'b0;
	logic                 link_clk = 1'b0;
	logic                 xtal = 1'b0;
	logic                 rstn, pg, req_a, req_b, strap, fsc, mid;
	logic                 scl, sda, sda_oe;
	logic                 oe0, oe1, oe2, ref_oe, fsc_o, trusted, tmode, pdown;
	logic                 pin0, pin2, sdo, pv;
	logic [1:0]           level;
	logic [NUM_PAIRS-1:0] run;
	logic [7:0]           rd;
	logic                 ok;
	int                   miscompares = 0;
	int                   cmp_count = 0;
	logic [7:0]           fnv [4] = '{8'h80, 8'hc0, 8'h20, 8'h30};
	int                   pr [4] = '{PAIR_A_SEL_0, PAIR_A_SEL_1, PAIR_B_SEL_0, PAIR_B_SEL_1};
	always #25 clk = ~clk;
	always #32 link_clk = ~link_clk;
	always #35 xtal = ~xtal;
	cps_top #(.DEV_ADDR(DEV)) u_cps_top (
		.CLK_I(clk), .RSTN_I(rstn), .LINK_CLK_I(link_clk),
		.SCLK_I(scl), .SDATA_I(sda), .SDATA_O(sdo), .SDATA_OE_O(sda_oe),
		.CLOCK_REQUEST_A_IN_I(req_a), .BUS_CLOCK_OUT_ZERO_O(pin0), .BUS_CLOCK_OUT_ZERO_OE_O(oe0),
		.CLOCK_REQUEST_B_IN_I(req_b), .BUS_CLOCK_OUT_ONE_O(), .BUS_CLOCK_OUT_ONE_OE_O(oe1),
		.TRUSTED_MODE_STRAP_I(strap), .BUS_CLOCK_OUT_TWO_O(pin2), .BUS_CLOCK_OUT_TWO_OE_O(oe2),
		.CPU_FREQ_SELECT_C_I(fsc), .TEST_SELECT_MID_I(mid), .XTAL_CLOCK_I(xtal),
		.REFERENCE_CLOCK_OUT_O(), .REFERENCE_CLOCK_OUT_OE_O(ref_oe),
		.POWER_GOOD_POWERDOWN_I(pg), .CPU_FREQ_SELECT_C_O(fsc_o), .TRUSTED_MODE_O(trusted),
		.TEST_LEVEL_O(level), .TEST_MODE_O(tmode), .POWER_DOWN_O(pdown),
		.REFERENCE_PAIR_RUN_O(run)
	);
	cps_smb_host #(.DEV_ADDR(DEV)) u_cps_smb_host (
		.clk_i(clk), .sdata_oe_i(sda_oe), .sclk_o(scl), .sdata_o(sda)
	);
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] off, input logic [7:0] v);
		u_cps_smb_host.smb_write(off, v, ok);
		chk("write ack", {7'h0, ok}, 8'h01);
	endtask
	task automatic reg_rd(input logic [7:0] off, input logic [7:0] exp);
		u_cps_smb_host.smb_read(off, rd, ok);
		chk("read ack", {7'h0, ok}, 8'h01);
		chk("read data", rd, exp);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		rstn = 1'b0;
		pg = 1'b0;
		req_a = 1'b0;
		req_b = 1'b0;
		strap = 1'b1;
		fsc = 1'b1;
		mid = 1'b0;
		tick(3);
		repeat (3) @(posedge link_clk);
		@(posedge clk);
		rstn <= 1'b1;
		tick(10);
		chk("power down before pg", {7'h0, pdown}, 8'h01);
		chk("pin zero enable before pg", {7'h0, oe0}, 8'h00);
		pg <= 1'b1;
		tick(20);
		chk("trusted strap", {7'h0, trusted}, 8'h01);
		chk("test level", {6'h0, level}, {6'h0, LVL_HIGH});
		chk("test mode", {7'h0, tmode}, 8'h01);
		chk("freq select", {7'h0, fsc_o}, 8'h01);
		chk("power down", {7'h0, pdown}, 8'h00);
		chk("pin two enable", {7'h0, oe2}, 8'h01);
		chk("pin zero enable", {7'h0, oe0}, 8'h01);
		chk("pin one enable", {7'h0, oe1}, 8'h01);
		chk("ref enable", {7'h0, ref_oe}, 8'h01);
		reg_rd(REG_OE_CTRL, OE_CTRL_RESET);
		reg_rd(REG_FN_CTRL, {FN_CTRL_RESET[7:4], 1'b1, LVL_HIGH, 1'b1});
		$display("test straps done");
		// straps change while powered down; they must not be taken again on return
		strap <= 1'b0;
		fsc <= 1'b0;
		pg <= 1'b0;
		tick(12);
		chk("power down", {7'h0, pdown}, 8'h01);
		chk("pin two off", {7'h0, oe2}, 8'h00);
		pg <= 1'b1;
		tick(20);
		chk("no relatch", {7'h0, trusted}, 8'h01);
		chk("resumed", {7'h0, oe2}, 8'h01);
		// sample between link edges so exactly one toggle falls in the window
		@(negedge link_clk);
		pv = pin2;
		@(negedge link_clk);
		chk("pin two toggles", {7'h0, pin2}, {7'h0, ~pv});
		chk("data drive level", {7'h0, sdo}, 8'h00);
		$display("test power down done");
		reg_wr(REG_OE_CTRL, 8'hfc);
		tick(20);
		chk("pin zero floats", {7'h0, oe0}, 8'h00);
		chk("pin one floats", {7'h0, oe1}, 8'h00);
		chk("pin zero parked", {7'h0, pin0}, 8'h00);
		chk("pin two kept", {7'h0, oe2}, 8'h01);
		reg_rd(REG_OE_CTRL, 8'hfc);
		for (int k = 0; k < 4; k++) begin
			reg_wr(REG_FN_CTRL, fnv[k]);
			if (k < 2) begin
				req_a <= 1'b1;
			end else begin
				req_b <= 1'b1;
			end
			tick(8);
			chk("pair stopped", {7'h0, run[pr[k]]}, 8'h00);
			chk("ungoverned pair", {7'h0, run[3]}, 8'h01);
			req_a <= 1'b0;
			req_b <= 1'b0;
			tick(8);
			chk("pair running", {7'h0, run[pr[k]]}, 8'h01);
			reg_rd(REG_FN_CTRL, fnv[k] | 8'h0f);
		end
		$display("test request pins done");
		reg_wr(REG_FN_CTRL, 8'h00);
		reg_wr(REG_OE_CTRL, 8'hff);
		tick(20);
		chk("pin zero back", {7'h0, oe0}, 8'h01);
		chk("pin one back", {7'h0, oe1}, 8'h01);
		reg_wr(8'h03, 8'h5a);
		reg_rd(8'h03, 8'h00);
		$display("test restore done");
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		complete_run();
	end
endmodule
